// [hw/mag_pkg.sv]
package mag_pkg;

	// ----------------------------------------------------------------
	// Register map (APB byte addresses, one word each)
	// ----------------------------------------------------------------
	localparam logic [7:0] MAG_CTRL_OFS = 8'h00;
	localparam logic [7:0] MAG_ARM_OFS = 8'h04;
	localparam logic [7:0] MAG_MTIME_OFS = 8'h08;
	localparam logic [7:0] MAG_SDLY_OFS = 8'h0C;
	localparam logic [7:0] MAG_NSAMP_OFS = 8'h10;
	localparam logic [7:0] MAG_CMD_OFS = 8'h14;
	localparam logic [7:0] MAG_STAT_OFS = 8'h18;
	localparam logic [7:0] MAG_RESULT_OFS = 8'h1C;
	localparam logic [7:0] MAG_SIDX_OFS = 8'h20;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int MAG_CTRL_HOLD_BIT = 0;
	localparam int MAG_CTRL_BLOCK_BIT = 1;
	localparam int MAG_CTRL_BUSTRG_BIT = 2;
	localparam int MAG_CTRL_FUNC_LSB = 4;
	localparam int MAG_ARM_START_LSB = 0;
	localparam int MAG_ARM_STOP_LSB = 2;
	localparam int MAG_ARM_SRC_LSB = 4;
	localparam int MAG_ARM_SDLYEN_BIT = 6;
	localparam int MAG_CMD_RESTART_BIT = 0;
	localparam int MAG_CMD_BUSTRG_BIT = 1;

	// ----------------------------------------------------------------
	// Timing: times in ns, counts of 10 ns ticks
	// ----------------------------------------------------------------
	localparam longint MAG_CLK_PERIOD_NS = 8;
	localparam longint MAG_TICK_NS = 10;
	localparam longint MAG_MTIME_DEF_NS = 200_000_000;
	localparam longint MAG_MTIME_MIN_NS = 20;
	localparam longint MAG_MTIME_MAX_NS = 1_000_000_000_000;
	localparam longint MAG_SDLY_MIN_NS = 10;
	localparam longint MAG_SDLY_MAX_NS = 2_000_000_000;
	localparam logic [36:0] MAG_MTIME_DEF_TK =
		37'(MAG_MTIME_DEF_NS / MAG_TICK_NS);
	localparam logic [36:0] MAG_MTIME_MIN_TK =
		37'(MAG_MTIME_MIN_NS / MAG_TICK_NS);
	localparam logic [36:0] MAG_MTIME_MAX_TK =
		37'(MAG_MTIME_MAX_NS / MAG_TICK_NS);
	localparam logic [27:0] MAG_SDLY_MIN_TK =
		28'(MAG_SDLY_MIN_NS / MAG_TICK_NS);
	localparam logic [27:0] MAG_SDLY_MAX_TK =
		28'(MAG_SDLY_MAX_NS / MAG_TICK_NS);
	// 10 ns tick from an 8 ns clock: fractional accumulator, 4 per 5 clocks
	localparam logic [3:0] MAG_TICK_ACC_ADD = 4'(MAG_CLK_PERIOD_NS);
	localparam logic [3:0] MAG_TICK_ACC_MOD = 4'(MAG_TICK_NS);

	// ----------------------------------------------------------------
	// Enumerations
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		MAG_SLOPE_OFF = 2'b00,
		MAG_SLOPE_RISE = 2'b01,
		MAG_SLOPE_FALL = 2'b10
	} mag_slope_type;

	typedef enum logic [1:0] {
		MAG_SRC_E = 2'b00,
		MAG_SRC_A = 2'b01,
		MAG_SRC_B = 2'b10
	} mag_src_type;

	typedef enum logic [2:0] {
		MAG_FN_FREQ = 3'b000,
		MAG_FN_PERAVG = 3'b001,
		MAG_FN_SINGLE = 3'b010,
		MAG_FN_BURST = 3'b011,
		MAG_FN_RATIO = 3'b100,
		MAG_FN_VOLT = 3'b101,
		MAG_FN_RISEFALL = 3'b110,
		MAG_FN_TOTTIMED = 3'b111
	} mag_func_type;

	typedef enum logic [2:0] {
		MAG_ST_IDLE = 3'b000,
		MAG_ST_PREP = 3'b001,
		MAG_ST_ARM = 3'b010,
		MAG_ST_WTRIG = 3'b011,
		MAG_ST_GATE = 3'b100,
		MAG_ST_DONE = 3'b101
	} mag_state_type;

endpackage : mag_pkg

// [hw/mag_tick_if.sv]
`timescale 1ns/1ps
`default_nettype none
// Delay timer control and status between sequencer and timer
interface mag_tick_if;
	logic tick;
	logic start;
	logic clear;
	logic [27:0] load;
	logic expired;
	modport seq (output start, output clear, output load, output tick,
		input expired);
	modport tmr (input start, input clear, input load, input tick,
		output expired);
endinterface : mag_tick_if
`default_nettype wire

// [hw/mag_delay_timer.sv]
`timescale 1ns/1ps
`default_nettype none
module mag_delay_timer (
	input wire logic core_clk_i, // Core clock
	input wire logic rstn_i, // Async reset, active low
	mag_tick_if.tmr ctl // Timer control
);
	import mag_pkg::*;

	logic [27:0] cnt_q;
	logic run_q;
	logic expired_q;
	logic last_tick;

	// --------------------------------------------------------------
	// Arming delay countdown in 10 ns ticks
	// --------------------------------------------------------------
	assign last_tick = run_q && ctl.tick && (cnt_q == 28'h0000001);
	assign ctl.expired = expired_q;

	// Clear wins over start so a restart cannot leave a stale expiry
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cnt_q <= 28'h0000000;
			run_q <= 1'b0;
			expired_q <= 1'b0;
		end else if (ctl.clear) begin // RULE25
			cnt_q <= 28'h0000000;
			run_q <= 1'b0;
			expired_q <= 1'b0;
		end else if (ctl.start) begin // RULE25
			cnt_q <= ctl.load;
			run_q <= 1'b1;
			expired_q <= 1'b0;
		end else if (last_tick) begin
			cnt_q <= 28'h0000000;
			run_q <= 1'b0;
			expired_q <= 1'b1; // RULE25
		end else if (run_q && ctl.tick) begin
			cnt_q <= cnt_q - 28'h0000001;
		end
	end

	// Expiry can only follow a load of at least one tick
	expiry_after_run_a: assert property (@(posedge core_clk_i)
		disable iff (!rstn_i)
		$rose(expired_q) |-> $past(run_q) && !run_q) // RULE25
		else $error("delay expiry without a running count");

endmodule : mag_delay_timer
`default_nettype wire

// [hw/mag_gate_ctrl.sv]
// Function
// [RULE1] Interval only for frequency/period average, 200ms default
// [RULE2] Interval quantised to 10 ns ticks
// [RULE3] Zero interval becomes 20 ns minimum
// [RULE4] Gate indicator high exactly while counting
// [RULE5] Hold finishes current measurement, keeps result
// [RULE6] Hold in block finishes sample, keeps samples
// [RULE7] Restart begins at sample one, stops at count
// [RULE8] Start/stop arming: rise, fall or off
// [RULE9] Start arming delay 10 ns to 2 s
// [RULE10] Arming source E, A or B; E default
// [RULE11] Start arming ignored for burst, ratio, volt
// [RULE12] Averaging: arming gates only first sample
// [RULE13] Stop arming blocks end until arming edge
// [RULE14] Stop arming ignored for burst/ratio/volt/risefall
// [RULE15] Stop delay only for timed totalize
// [RULE16] Free-run restarts immediately after finishing
// [RULE17] Start order: processed, prepared, then trigger
// [RULE18] Stop at first stop trigger after interval
// [RULE19] Restart, bus trigger, arming, delay gate start
// [RULE20] Dead time between block samples below 2 us
// [RULE21] Start arming disables free-run, edge per measurement
// [RULE22] Start plus stop arming gives external gate
// [RULE23] Arming edge must lead start trigger
// [RULE24] Trigger must come 40 ns after delay
// [RULE25] Delay timer ticks, expires, clears on restart
`timescale 1ns/1ps
`default_nettype none
module mag_gate_ctrl #(
	parameter int NSAMP_W = 16 // Width of sample count
) (
	input wire logic core_clk_i, // Core clock, 125 MHz
	input wire logic rstn_i, // Async reset, active low
	input wire logic [7:0] paddr_i, // APB address
	input wire logic psel_i, // APB select
	input wire logic penable_i, // APB enable
	input wire logic pwrite_i, // APB write
	input wire logic [31:0] pwdata_i, // APB write data
	output logic [31:0] prdata_o, // APB read data
	output logic pready_o, // APB ready
	output logic pslverr_o, // APB error
	input wire logic trig_start_i, // Start trigger event on measuring input
	input wire logic trig_stop_i, // Stop trigger event on measuring input
	input wire logic arm_e_i, // Rear arming input level
	input wire logic arm_a_i, // Measuring input A level
	input wire logic arm_b_i, // Measuring input B level
	input wire logic result_done_i, // Previous result fully processed
	input wire logic [31:0] result_i, // Result of the finished measurement
	output logic gate_o, // Gate active indicator
	output logic meas_done_o, // Pulse when a result is complete
	output logic [31:0] last_result_o // Last completed result
);
	import mag_pkg::*;

	localparam int IDX_W = NSAMP_W;
	// Sample count must fit the 32-bit read word
	if (NSAMP_W < 1 || NSAMP_W > 32) begin : g_bad_nsamp
		$error("NSAMP_W out of range");
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic hold_q, block_q, bustrg_en_q, sdly_en_q;
	logic [2:0] func_q;
	logic [1:0] start_slope_q, stop_slope_q, src_q;
	logic [36:0] mtime_q;
	logic [27:0] sdly_q;
	logic [NSAMP_W-1:0] nsamp_q;
	logic [IDX_W-1:0] sidx_q;
	logic [31:0] result_q;
	logic restart_q, bustrg_q;
	logic arm_lvl_q, start_armed_q, stop_armed_q, first_q;
	logic [36:0] mcnt_q;
	logic mtime_up_q;
	logic [3:0] acc_q;
	logic tick_q;
	logic hold_pend_q;
	mag_state_type state_q, state_d;

	mag_tick_if dly_if ();

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	logic wr_en, rd_en, cmd_wr, restart_wr, bustrg_wr;
	logic hit_ctrl, hit_arm, hit_mtime, hit_sdly, hit_nsamp, hit_cmd;
	logic hit_stat, hit_result, hit_sidx, hit_any;
	assign wr_en = psel_i && penable_i && pwrite_i;
	assign rd_en = psel_i && !pwrite_i;
	assign hit_ctrl = paddr_i == MAG_CTRL_OFS;
	assign hit_arm = paddr_i == MAG_ARM_OFS;
	assign hit_mtime = paddr_i == MAG_MTIME_OFS;
	assign hit_sdly = paddr_i == MAG_SDLY_OFS;
	assign hit_nsamp = paddr_i == MAG_NSAMP_OFS;
	assign hit_cmd = paddr_i == MAG_CMD_OFS;
	assign hit_stat = paddr_i == MAG_STAT_OFS;
	assign hit_result = paddr_i == MAG_RESULT_OFS;
	assign hit_sidx = paddr_i == MAG_SIDX_OFS;
	assign hit_any = hit_ctrl | hit_arm | hit_mtime | hit_sdly | hit_nsamp
		| hit_cmd | hit_stat | hit_result | hit_sidx;
	assign pready_o = 1'b1; // Zero wait states
	assign pslverr_o = psel_i && penable_i && !hit_any;
	assign cmd_wr = wr_en && hit_cmd;
	assign restart_wr = cmd_wr && pwdata_i[MAG_CMD_RESTART_BIT];
	assign bustrg_wr = cmd_wr && pwdata_i[MAG_CMD_BUSTRG_BIT];

	// Interval entry: zero picks minimum, values below it raised to it, 10 ns units
	logic [36:0] mtime_wr;
	assign mtime_wr = (pwdata_i == 32'h00000000) ? MAG_MTIME_MIN_TK // RULE3
		: ({5'h00, pwdata_i} < MAG_MTIME_MIN_TK) ? MAG_MTIME_MIN_TK
		: {5'h00, pwdata_i}; // RULE2
	logic [27:0] sdly_wr;
	assign sdly_wr = (pwdata_i[27:0] < MAG_SDLY_MIN_TK) ? MAG_SDLY_MIN_TK
		: (pwdata_i[27:0] > MAG_SDLY_MAX_TK) ? MAG_SDLY_MAX_TK
		: pwdata_i[27:0]; // RULE9

	// Config registers
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			hold_q <= 1'b0;
			block_q <= 1'b0;
			bustrg_en_q <= 1'b0;
			func_q <= MAG_FN_FREQ;
			start_slope_q <= MAG_SLOPE_OFF;
			stop_slope_q <= MAG_SLOPE_OFF;
			src_q <= MAG_SRC_E; // RULE10
			sdly_en_q <= 1'b0;
			mtime_q <= MAG_MTIME_DEF_TK; // RULE1
			sdly_q <= MAG_SDLY_MIN_TK;
			nsamp_q <= NSAMP_W'(1);
		end else if (wr_en) begin
			if (hit_ctrl) begin
				hold_q <= pwdata_i[MAG_CTRL_HOLD_BIT];
				block_q <= pwdata_i[MAG_CTRL_BLOCK_BIT];
				bustrg_en_q <= pwdata_i[MAG_CTRL_BUSTRG_BIT];
				func_q <= pwdata_i[MAG_CTRL_FUNC_LSB +: 3];
			end
			if (hit_arm) begin
				start_slope_q <= pwdata_i[MAG_ARM_START_LSB +: 2]; // RULE8
				stop_slope_q <= pwdata_i[MAG_ARM_STOP_LSB +: 2]; // RULE8
				src_q <= pwdata_i[MAG_ARM_SRC_LSB +: 2];
				sdly_en_q <= pwdata_i[MAG_ARM_SDLYEN_BIT];
			end
			if (hit_mtime) begin
				mtime_q <= mtime_wr;
			end
			if (hit_sdly) begin
				sdly_q <= sdly_wr;
			end
			if (hit_nsamp) begin
				nsamp_q <= pwdata_i[NSAMP_W-1:0];
			end
		end
	end

	// Read mux
	logic [31:0] stat_word;
	assign stat_word = {24'h000000, 1'b0, hold_pend_q, first_q,
		dly_if.expired, start_armed_q, state_q};
	always_comb begin
		prdata_o = 32'h00000000;
		if (rd_en) begin
			unique case (1'b1)
			hit_ctrl: prdata_o = {25'h0, func_q, 1'b0, bustrg_en_q,
				block_q, hold_q};
			hit_arm: prdata_o = {25'h0, sdly_en_q, src_q, stop_slope_q,
				start_slope_q};
			hit_mtime: prdata_o = mtime_q[31:0];
			hit_sdly: prdata_o = {4'h0, sdly_q};
			hit_nsamp: prdata_o = 32'(nsamp_q);
			hit_stat: prdata_o = stat_word;
			hit_result: prdata_o = result_q;
			hit_sidx: prdata_o = 32'(sidx_q);
			default: prdata_o = 32'h00000000;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Function qualification
	// ----------------------------------------------------------------
	logic is_avg, start_arm_on, stop_arm_on, stop_dly_on, sel_lvl;
	assign is_avg = (func_q == MAG_FN_FREQ) || (func_q == MAG_FN_PERAVG);
	assign start_arm_on = (start_slope_q != MAG_SLOPE_OFF)
		&& (func_q != MAG_FN_BURST) && (func_q != MAG_FN_RATIO)
		&& (func_q != MAG_FN_VOLT); // RULE11
	assign stop_arm_on = (stop_slope_q != MAG_SLOPE_OFF)
		&& (func_q != MAG_FN_BURST) && (func_q != MAG_FN_RATIO)
		&& (func_q != MAG_FN_VOLT) && (func_q != MAG_FN_RISEFALL); // RULE14
	// Stop delay is only the timed totalize mechanism
	assign stop_dly_on = (func_q == MAG_FN_TOTTIMED); // RULE15
	assign sel_lvl = (src_q == MAG_SRC_A) ? arm_a_i
		: (src_q == MAG_SRC_B) ? arm_b_i : arm_e_i; // RULE10

	// Edge detect on the chosen arming input, one cycle of lead needed
	logic arm_rise, arm_fall, start_edge, stop_edge;
	assign arm_rise = sel_lvl && !arm_lvl_q;
	assign arm_fall = !sel_lvl && arm_lvl_q;
	assign start_edge = (start_slope_q == MAG_SLOPE_RISE) ? arm_rise
		: (start_slope_q == MAG_SLOPE_FALL) ? arm_fall : 1'b0; // RULE23
	assign stop_edge = (stop_slope_q == MAG_SLOPE_RISE) ? arm_rise
		: (stop_slope_q == MAG_SLOPE_FALL) ? arm_fall : 1'b0;

	// ----------------------------------------------------------------
	// 10 ns tick and delay timer
	// ----------------------------------------------------------------
	// One spare bit: 8 + 8 would wrap a 4-bit sum and stop the tick
	logic [4:0] acc_sum;
	logic acc_wrap;
	assign acc_sum = {1'b0, acc_q} + {1'b0, MAG_TICK_ACC_ADD};
	assign acc_wrap = acc_sum >= {1'b0, MAG_TICK_ACC_MOD};
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			acc_q <= 4'h0;
			tick_q <= 1'b0;
		end else begin
			acc_q <= acc_wrap ? 4'(acc_sum - {1'b0, MAG_TICK_ACC_MOD})
				: acc_sum[3:0];
			tick_q <= acc_wrap;
		end
	end

	logic need_arm, arm_seen;
	// Arming needed for first sample of averaging block or every single
	assign need_arm = start_arm_on && (first_q || !block_q); // RULE12 RULE21
	assign dly_if.tick = tick_q;
	assign dly_if.load = sdly_q;
	assign dly_if.start = (state_q == MAG_ST_ARM) && start_edge
		&& sdly_en_q && !start_armed_q; // RULE9
	// Expiry is spent by the start it allowed; the next needs a new edge
	assign dly_if.clear = restart_wr || !start_arm_on
		|| (state_q == MAG_ST_WTRIG); // RULE25
	// Trigger taken only once delay has expired; the far side keeps margin
	assign arm_seen = sdly_en_q ? dly_if.expired : start_armed_q; // RULE24

	mag_delay_timer u_dly (
		.core_clk_i(core_clk_i),
		.rstn_i(rstn_i),
		.ctl(dly_if)
	);

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	logic start_ok, stop_ok, blk_full, blk_last, hold_stop;
	logic [IDX_W:0] sidx_nxt;
	// Manual restart in hold and bus trigger both qualify the start
	assign start_ok = (!hold_q || restart_q) && (!bustrg_en_q || bustrg_q)
		&& (!need_arm || arm_seen); // RULE19
	assign stop_ok = trig_stop_i && (!is_avg || mtime_up_q) // RULE18
		&& (!stop_arm_on || stop_armed_q || stop_dly_on); // RULE13 RULE22
	assign blk_full = block_q && (sidx_q >= nsamp_q); // RULE7
	// Done state looks one sample ahead, its count lands at that edge
	assign sidx_nxt = {1'b0, sidx_q} + {{IDX_W{1'b0}}, 1'b1};
	assign blk_last = block_q && (sidx_nxt >= {1'b0, nsamp_q}); // RULE7
	assign hold_stop = hold_q || hold_pend_q || blk_last; // RULE5 RULE6

	always_comb begin
		state_d = state_q;
		unique case (state_q)
		MAG_ST_IDLE: if (restart_q || (!hold_q && !blk_full)) begin
			state_d = MAG_ST_PREP;
		end
		MAG_ST_PREP: if (result_done_i) begin // RULE17
			state_d = MAG_ST_ARM;
		end
		MAG_ST_ARM: if (start_ok) begin
			state_d = MAG_ST_WTRIG;
		end
		MAG_ST_WTRIG: if (trig_start_i) begin // RULE17
			state_d = MAG_ST_GATE;
		end
		MAG_ST_GATE: if (stop_ok) begin
			state_d = MAG_ST_DONE;
		end
		// Free-run loops straight back; dead time is a few cycles
		MAG_ST_DONE: state_d = hold_stop ? MAG_ST_IDLE : MAG_ST_PREP;
		default: state_d = MAG_ST_IDLE;
		endcase
	end // RULE16 RULE20

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_q <= MAG_ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// Arming, request latches and interval counting
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			arm_lvl_q <= 1'b0;
			start_armed_q <= 1'b0;
			stop_armed_q <= 1'b0;
			restart_q <= 1'b0;
			bustrg_q <= 1'b0;
			mcnt_q <= 37'h0;
			mtime_up_q <= 1'b0;
		end else begin
			arm_lvl_q <= sel_lvl;
			// Set wins: a restart written as one is consumed is kept
			restart_q <= restart_wr || (restart_q && !(state_q == MAG_ST_ARM
				&& start_ok));
			bustrg_q <= bustrg_wr || (bustrg_q && !(state_q == MAG_ST_ARM
				&& start_ok));
			if (state_q == MAG_ST_ARM && start_edge && !sdly_en_q) begin
				start_armed_q <= 1'b1;
			end else if (state_q == MAG_ST_WTRIG || restart_wr) begin
				start_armed_q <= 1'b0; // RULE21
			end
			if (state_q == MAG_ST_GATE && stop_edge) begin
				stop_armed_q <= 1'b1;
			end else if (state_q != MAG_ST_GATE) begin
				stop_armed_q <= 1'b0;
			end
			if (state_q != MAG_ST_GATE) begin
				mcnt_q <= 37'h0;
				mtime_up_q <= 1'b0;
			end else if (tick_q && !mtime_up_q) begin
				mcnt_q <= mcnt_q + 37'h1;
				mtime_up_q <= (mcnt_q + 37'h1) >= mtime_q; // RULE1 RULE2
			end
		end
	end

	// Block bookkeeping and result
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sidx_q <= '0;
			first_q <= 1'b1;
			hold_pend_q <= 1'b0;
			result_q <= 32'h00000000;
		end else begin
			if (restart_wr) begin
				sidx_q <= '0; // RULE7
				first_q <= 1'b1;
				hold_pend_q <= 1'b0;
			end else if (state_q == MAG_ST_DONE) begin
				sidx_q <= sidx_q + IDX_W'(1);
				first_q <= 1'b0;
			end else if (hold_q && state_q != MAG_ST_IDLE) begin
				hold_pend_q <= 1'b1; // RULE6
			end
			if (state_q == MAG_ST_DONE) begin
				result_q <= result_i; // RULE5
			end
		end
	end

	assign gate_o = (state_q == MAG_ST_GATE); // RULE4
	assign meas_done_o = (state_q == MAG_ST_DONE);
	assign last_result_o = result_q;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	gate_open_trig_a: assert property (@(posedge core_clk_i)
		disable iff (!rstn_i)
		$rose(gate_o) |-> $past(trig_start_i)) // RULE4
		else $error("gate opened without start trigger");
	gate_close_stop_a: assert property (@(posedge core_clk_i)
		disable iff (!rstn_i)
		$fell(gate_o) |-> $past(trig_stop_i)) // RULE18
		else $error("gate closed without stop trigger");
	interval_before_stop_a: assert property (@(posedge core_clk_i)
		disable iff (!rstn_i)
		$fell(gate_o) && $past(is_avg) |-> $past(mtime_up_q)) // RULE18
		else $error("stop before interval elapsed");
	stop_arm_hold_a: assert property (@(posedge core_clk_i)
		disable iff (!rstn_i)
		$fell(gate_o) && $past(stop_arm_on) && !$past(stop_dly_on)
		|-> $past(stop_armed_q)) // RULE13
		else $error("stop without stop arming edge");
	hold_keeps_result_a: assert property (@(posedge core_clk_i)
		disable iff (!rstn_i)
		state_q == MAG_ST_IDLE && hold_q && !restart_q
		|=> $stable(result_q)) // RULE5
		else $error("result changed while held");
	min_interval_a: assert property (@(posedge core_clk_i)
		disable iff (!rstn_i)
		mtime_q >= MAG_MTIME_MIN_TK) // RULE3
		else $error("interval below minimum");
	freerun_next_a: assert property (@(posedge core_clk_i)
		disable iff (!rstn_i)
		state_q == MAG_ST_DONE && !hold_stop |=> state_q == MAG_ST_PREP)
		// RULE16
		else $error("free-run did not relaunch");
	block_stop_a: assert property (@(posedge core_clk_i)
		disable iff (!rstn_i)
		state_q == MAG_ST_IDLE && blk_full && !restart_q && !restart_wr
		|=> state_q == MAG_ST_IDLE) // RULE7
		else $error("block ran past sample count");
	armed_start_a: assert property (@(posedge core_clk_i)
		disable iff (!rstn_i)
		state_q == MAG_ST_ARM && state_d == MAG_ST_WTRIG && need_arm
		|-> arm_seen) // RULE21
		else $error("start without arming");

endmodule : mag_gate_ctrl
`default_nettype wire

// [sim/mag_sig_src.sv]
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Measured signal source and result processing model
// ----------------------------------------------------------------
module mag_sig_src (
	input wire logic core_clk_i, // Core clock
	input wire logic rstn_i, // Reset, active low
	input wire logic en_i, // Let processing complete at all
	output logic trig_start_o, // Start trigger pulse
	output logic trig_stop_o, // Stop trigger pulse
	output logic arm_a_o, // Input A level
	output logic arm_b_o, // Input B level
	output logic done_o // Result processed
);
	logic [7:0] ph_q;
	// Phase counter; the signal keeps triggering whether armed or not
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ph_q <= 8'h00;
		end else begin
			ph_q <= ph_q + 8'h01;
		end
	end
	// Start and stop events never share a cycle
	assign trig_start_o = (ph_q[2:0] == 3'h3);
	assign trig_stop_o = (ph_q[1:0] == 2'h1);
	assign arm_a_o = ph_q[4];
	assign arm_b_o = ph_q[0];
	// Slow processing now and then, so waits are exercised
	assign done_o = en_i & (~ph_q[5] | ph_q[1]);
endmodule : mag_sig_src
`default_nettype wire

// [sim/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import mag_pkg::*;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, arm_e = 1'b0, en = 1'b0;
	logic [7:0] pa = 8'h00;
	logic [31:0] pwd = 32'h0, res = 32'h0;
	logic [31:0] prd, lres, rv, exp_res;
	logic prdy, perr, er, ts, tp, aa, ab, rdy, gate, mdone;
	logic ts1 = 1'b0, tp1 = 1'b0, g1 = 1'b0, chk = 1'b0, timed = 1'b1;
	int miscompares = 0, n_compared = 0, cyc = 0, n_done = 0, glen = 0;
	int n0;
	integer seed = 32'h50154036;
	logic [31:0] rst_tab [5] = '{32'h0, 32'h0, 32'h01312D00, 32'h1, 32'h1};

	initial forever #4 clk = ~clk;

	mag_gate_ctrl #(.NSAMP_W(16)) i_mag_gate_ctrl (.core_clk_i(clk),
		.rstn_i(rstn), .paddr_i(pa), .psel_i(psel), .penable_i(pen),
		.pwrite_i(pwr), .pwdata_i(pwd), .prdata_o(prd), .pready_o(prdy),
		.pslverr_o(perr), .trig_start_i(ts), .trig_stop_i(tp),
		.arm_e_i(arm_e), .arm_a_i(aa), .arm_b_i(ab), .result_done_i(rdy),
		.result_i(res), .gate_o(gate), .meas_done_o(mdone),
		.last_result_o(lres));
	mag_sig_src i_mag_sig_src (.core_clk_i(clk), .rstn_i(rstn), .en_i(en),
		.trig_start_o(ts), .trig_stop_o(tp), .arm_a_o(aa), .arm_b_o(ab),
		.done_o(rdy));

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask : cmp

	task automatic report_and_stop();
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : report_and_stop

	// One APB transfer; request held until pready is seen at an edge
	task automatic apb(input logic [7:0] a, input logic w,
		input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pen <= 1'b0;
		pa <= a;
		pwr <= w;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (prdy !== 1'b1);
		rv = prd;
		er = perr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask : apb

	task automatic waitn(input int n);
		repeat (800) begin
			@(posedge clk);
			if (n_done >= n) break;
		end
		cmp(32'(n_done >= n), 32'h1);
	endtask : waitn

	// Long enough for several measurements of 3 ticks each
	task automatic quiet(input int n);
		repeat (300) @(posedge clk);
		cmp(32'(n_done), 32'(n));
	endtask : quiet

	// ----------------------------------------------------------------
	// Monitor: reads pre-edge values, so no race with the design
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		cyc <= cyc + 1;
		ts1 <= ts;
		tp1 <= tp;
		g1 <= gate;
		glen <= gate ? glen + 1 : 0;
		chk <= mdone;
		if (gate && !g1) cmp(32'(ts1), 32'h1);
		if (mdone) begin
			n_done <= n_done + 1;
			exp_res <= res;
			cmp(32'(tp1 & ~gate), 32'h1);
			cmp(32'(!timed || glen >= 4), 32'h1);
		end
		if (chk) begin
			cmp(lres, exp_res);
			res <= $random(seed);
		end
		if (cyc == 30000) begin
			miscompares++;
			report_and_stop();
		end
	end

	initial begin
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			apb(8'(i * 4), 1'b0, 32'h0);
			cmp(rv, rst_tab[i]);
		end
		apb(8'h40, 1'b0, 32'h0);
		cmp(32'(er), 32'h1);
		apb(MAG_MTIME_OFS, 1'b1, 32'h0);
		apb(MAG_MTIME_OFS, 1'b0, 32'h0);
		cmp(rv, 32'h2);
		apb(MAG_MTIME_OFS, 1'b1, 32'h3);
		apb(MAG_MTIME_OFS, 1'b0, 32'h0);
		cmp(rv, 32'h3);
		$display("registers done");
		en <= 1'b1;
		waitn(3);
		// Hold arrives mid-gate: that one ends, then nothing more
		wait (gate === 1'b1);
		apb(MAG_CTRL_OFS, 1'b1, 32'h1);
		repeat (50) @(posedge clk);
		n0 = n_done;
		quiet(n0);
		apb(MAG_CMD_OFS, 1'b1, 32'h1);
		quiet(n0 + 1);
		apb(MAG_CTRL_OFS, 1'b1, 32'h4);
		quiet(n0 + 1);
		apb(MAG_CMD_OFS, 1'b1, 32'h2);
		quiet(n0 + 2);
		$display("hold and bus trigger done");
		// One arming edge, one measurement
		apb(MAG_ARM_OFS, 1'b1, 32'h1);
		apb(MAG_CTRL_OFS, 1'b1, 32'h0);
		quiet(n0 + 2);
		arm_e <= 1'b1;
		quiet(n0 + 3);
		apb(MAG_ARM_OFS, 1'b1, 32'h2);
		arm_e <= 1'b0;
		quiet(n0 + 4);
		// Delayed arming: one edge, one start, expiry spent by it
		apb(MAG_SDLY_OFS, 1'b1, 32'h0);
		apb(MAG_SDLY_OFS, 1'b0, 32'h0);
		cmp(rv, 32'h1);
		apb(MAG_SDLY_OFS, 1'b1, 32'h20);
		apb(MAG_ARM_OFS, 1'b1, 32'h41);
		arm_e <= 1'b1;
		quiet(n0 + 5);
		timed = 1'b0;
		arm_e <= 1'b0;
		apb(MAG_CTRL_OFS, 1'b1, 32'h30);
		waitn(n0 + 7);
		$display("start arming done");
		// Arming from input B, which rises every other cycle
		apb(MAG_CTRL_OFS, 1'b1, 32'h0);
		apb(MAG_ARM_OFS, 1'b1, 32'h21);
		timed = 1'b1;
		n0 = n_done;
		waitn(n0 + 2);
		// Block of three: only the first sample waits for arming
		apb(MAG_CTRL_OFS, 1'b1, 32'h2);
		repeat (30) @(posedge clk);
		apb(MAG_ARM_OFS, 1'b1, 32'h1);
		apb(MAG_NSAMP_OFS, 1'b1, 32'h3);
		apb(MAG_CMD_OFS, 1'b1, 32'h1);
		n0 = n_done;
		quiet(n0);
		arm_e <= 1'b1;
		quiet(n0 + 3);
		$display("source and block done");
		// Stop arming keeps the gate open until the edge
		apb(MAG_CTRL_OFS, 1'b1, 32'h0);
		apb(MAG_ARM_OFS, 1'b1, 32'h4);
		arm_e <= 1'b0;
		repeat (100) @(posedge clk);
		wait (gate === 1'b1);
		repeat (200) @(posedge clk);
		cmp(32'(gate), 32'h1);
		n0 = n_done;
		arm_e <= 1'b1;
		waitn(n0 + 1);
		$display("stop arming done");
		report_and_stop();
	end
endmodule : tb_top
`default_nettype wire
